// >>> shared/diag_params.svh
`ifndef DIAG_PARAMS_SVH
`define DIAG_PARAMS_SVH

// ****************************************************************
// Register addresses
// ****************************************************************
`define ADDR_CHECK_ENABLE      7'h21
`define ADDR_ERROR_FLAGS       7'h22
`define ADDR_OPEN_ENABLE       7'h23
`define ADDR_OPEN_FLAGS        7'h24
`define ADDR_RANGE_ENABLE      7'h25
`define ADDR_OVER_FLAGS        7'h26
`define ADDR_UNDER_FLAGS       7'h27
`define ADDR_MAP_LAST          7'h2F

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_CHECK_ENABLE       8'h01
`define RST_FLAGS              8'h00

// ****************************************************************
// Field positions in enable and error registers
// ****************************************************************
`define BIT_PATTERN            7
`define BIT_SAMPLE_COUNT       6
`define BIT_BUSY_STUCK         5
`define BIT_BAD_READ           4
`define BIT_BAD_WRITE          3
`define BIT_IF_CRC             2
`define BIT_MAP_CRC            1
`define BIT_ROM_CRC            0
`define ERR_USED_MASK          8'h3F

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS          40
`define BUSY_STUCK_NS          4000
`define BUSY_STUCK_CYC         (`BUSY_STUCK_NS / `CLK_PERIOD_NS)

`endif

// >>> shared/diag_pkg.sv
package diag_pkg;
   typedef logic [7:0] byte_type;
   typedef logic [6:0] addr_type;
   typedef enum logic [0:0] {
      OPEN_AUTO   = 1'b0,
      OPEN_MANUAL = 1'b1
   } open_mode_type;
endpackage

// >>> core/diag_monitor.sv
// Notes on behaviour
// RULE1: Pattern enable bit 7 replaces conversion data with a fixed value.
// RULE2: Bit 6 switches on the sample and oversampling clock event counter.
// RULE3: Bit 5 enables busy-stuck supervision; off after reset.
// RULE4: Busy high over 4 us while enabled sets error bit 5.
// RULE5: Bit 4 enabled: read of unmapped address sets error bit 4.
// RULE6: Bit 3 enabled: write to unmapped address sets error bit 3.
// RULE7: Bit 2 enables interface CRC check; failure sets error bit 2.
// RULE8: Bit 1 enables register map CRC check; mismatch sets bit 1.
// RULE9: Bit 0 enables ROM CRC check, resets to one; failure sets bit 0.
// RULE10: Error bits 5..0 reset zero, clear on write one; 7..6 read zero.
// RULE11: Auto open mode: open enable bit n enables channel n+1 detection.
// RULE12: Manual open mode: open enable bit drives amplifier common mode high.
// RULE13: Channel open sets open flag bit n; write one clears it.
// RULE14: Range enable bit n enables channel n+1 range supervision.
// RULE15: Overvoltage on channel n+1 sets over flag bit n; W1C.
// RULE16: Undervoltage on channel n+1 sets under flag bit n; W1C.
// RULE17: Digital check enable register at 0x21, reset value 0x01.
// RULE18: Flags set only while enabled and stay set until cleared.
// RULE19: Host clears flags with a mask holding ones only where intended.
`timescale 1ns/100ps
`include "diag_params.svh"

module diag_monitor #(
   parameter int            COUNT_W    = 16,
   parameter diag_pkg::byte_type PATTERN = 8'hA5,
   parameter int            BUSY_LIMIT = `BUSY_STUCK_CYC
) (
   input  wire logic               ref_clk,
   input  wire logic               arst_n,
   input  wire logic               reg_wr,
   input  wire logic               reg_rd,
   input  wire diag_pkg::addr_type reg_addr,
   input  wire diag_pkg::byte_type reg_wdata,
   output      diag_pkg::byte_type reg_rdata,
   input  wire diag_pkg::open_mode_type open_mode,
   input  wire logic               busy_pin,
   input  wire logic               conversion_start_clock,
   input  wire logic               oversampling_clock,
   input  wire logic               if_crc_fail,
   input  wire logic               map_crc_fail,
   input  wire logic               rom_crc_fail,
   input  wire diag_pkg::byte_type chan_open_event,
   input  wire diag_pkg::byte_type chan_over_event,
   input  wire diag_pkg::byte_type chan_under_event,
   input  wire logic [15:0]        conv_data_in,
   output      logic [15:0]        conv_data_out,
   output      diag_pkg::byte_type chan_open_check_enable,
   output      diag_pkg::byte_type chan_cm_high,
   output      diag_pkg::byte_type chan_range_check_enable,
   output      logic [COUNT_W-1:0] sample_clock_count
);
   import diag_pkg::*;

   // ****************************************************************
   // Functions
   // ****************************************************************
   function automatic byte_type w1c(input byte_type cur,
                                    input byte_type set,
                                    input logic     clr,
                                    input byte_type mask);
      // Set wins over clear in the same cycle
      w1c = (cur & ~(clr ? mask : 8'h00)) | set;
   endfunction

   function automatic logic is_mapped(input addr_type a);
      is_mapped = (a <= `ADDR_MAP_LAST);
   endfunction

   // ****************************************************************
   // Input synchronisers
   // ****************************************************************
   logic [7:0]  sync1_r;
   logic [7:0]  sync2_r;
   logic        start_d_r;
   logic        ovs_d_r;
   byte_type    ch1_r [3];
   byte_type    ch2_r [3];

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1_r <= 8'h00;
         sync2_r <= 8'h00;
      end else begin
         sync1_r <= {2'b00, rom_crc_fail, map_crc_fail, if_crc_fail,
                     oversampling_clock, conversion_start_clock,
                     busy_pin};
         sync2_r <= sync1_r;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ch1_r[0] <= 8'h00;
         ch1_r[1] <= 8'h00;
         ch1_r[2] <= 8'h00;
         ch2_r[0] <= 8'h00;
         ch2_r[1] <= 8'h00;
         ch2_r[2] <= 8'h00;
      end else begin
         ch1_r[0] <= chan_open_event;
         ch1_r[1] <= chan_over_event;
         ch1_r[2] <= chan_under_event;
         ch2_r    <= ch1_r;
      end
   end

   logic busy_s;
   logic start_s;
   logic ovs_s;
   assign busy_s  = sync2_r[0];
   assign start_s = sync2_r[1];
   assign ovs_s   = sync2_r[2];

   // ****************************************************************
   // Control registers
   // ****************************************************************
   byte_type check_en_r;
   byte_type open_en_r;
   byte_type range_en_r;
   logic     wr_en;
   logic     rd_en;
   assign wr_en = reg_wr;
   assign rd_en = reg_rd & ~reg_wr;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         check_en_r <= `RST_CHECK_ENABLE; // RULE3 RULE9 RULE17
         open_en_r  <= `RST_FLAGS;        // RULE11
         range_en_r <= `RST_FLAGS;        // RULE14
      end else if (wr_en) begin
         case (reg_addr)
            `ADDR_CHECK_ENABLE: check_en_r <= reg_wdata; // RULE17
            `ADDR_OPEN_ENABLE:  open_en_r  <= reg_wdata;
            `ADDR_RANGE_ENABLE: range_en_r <= reg_wdata; // RULE14
            default: ;
         endcase
      end
   end

   // ****************************************************************
   // Open-detect and range outputs
   // ****************************************************************
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         chan_open_check_enable  <= 8'h00;
         chan_cm_high            <= 8'h00;
         chan_range_check_enable <= 8'h00;
      end else begin
         chan_open_check_enable  <= (open_mode == OPEN_AUTO) ?
                                    open_en_r : 8'h00; // RULE11
         chan_cm_high            <= (open_mode == OPEN_MANUAL) ?
                                    open_en_r : 8'h00; // RULE12
         chan_range_check_enable <= range_en_r;        // RULE14
      end
   end

   // ****************************************************************
   // Busy-stuck watchdog
   // ****************************************************************
   logic [15:0] busy_cnt_r;
   logic        busy_stuck;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         busy_cnt_r <= 16'h0000;
      end else if (!busy_s || !check_en_r[`BIT_BUSY_STUCK]) begin
         busy_cnt_r <= 16'h0000; // RULE3
      end else if (busy_cnt_r <= 16'(BUSY_LIMIT)) begin
         busy_cnt_r <= busy_cnt_r + 16'h0001;
      end
   end
   // Still high after the full limit, so longer than it
   assign busy_stuck = busy_s
                       & (busy_cnt_r >= 16'(BUSY_LIMIT)); // RULE4

   // ****************************************************************
   // Sample clock event counter
   // ****************************************************************
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         start_d_r <= 1'b0;
         ovs_d_r   <= 1'b0;
      end else begin
         start_d_r <= start_s;
         ovs_d_r   <= ovs_s;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         sample_clock_count <= '0;
      end else if (check_en_r[`BIT_SAMPLE_COUNT]) begin // RULE2
         sample_clock_count <= sample_clock_count
            + COUNT_W'(start_s & ~start_d_r) + COUNT_W'(ovs_s & ~ovs_d_r);
      end
   end

   // ****************************************************************
   // Conversion data path
   // ****************************************************************
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         conv_data_out <= 16'h0000;
      end else if (check_en_r[`BIT_PATTERN]) begin
         conv_data_out <= {PATTERN, PATTERN}; // RULE1
      end else begin
         conv_data_out <= conv_data_in;
      end
   end

   // ****************************************************************
   // Sticky flags
   // ****************************************************************
   byte_type err_r;
   byte_type open_r;
   byte_type over_r;
   byte_type under_r;
   byte_type err_set;
   logic     bad_addr;
   assign bad_addr = ~is_mapped(reg_addr);

   always_comb begin
      err_set = 8'h00;
      err_set[`BIT_BUSY_STUCK] = busy_stuck;                        // RULE4
      err_set[`BIT_BAD_READ]   = rd_en & bad_addr
                                 & check_en_r[`BIT_BAD_READ];       // RULE5
      err_set[`BIT_BAD_WRITE]  = wr_en & bad_addr
                                 & check_en_r[`BIT_BAD_WRITE];      // RULE6
      err_set[`BIT_IF_CRC]     = sync2_r[3] & check_en_r[`BIT_IF_CRC]; // RULE7
      err_set[`BIT_MAP_CRC]    = sync2_r[4]
                                 & check_en_r[`BIT_MAP_CRC];        // RULE8
      err_set[`BIT_ROM_CRC]    = sync2_r[5]
                                 & check_en_r[`BIT_ROM_CRC];        // RULE9
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         err_r   <= `RST_FLAGS; // RULE10
         open_r  <= `RST_FLAGS;
         over_r  <= `RST_FLAGS;
         under_r <= `RST_FLAGS;
      end else begin
         // Held until a one is written, regardless of the fault
         err_r   <= w1c(err_r, err_set,
                        wr_en && reg_addr == `ADDR_ERROR_FLAGS,
                        reg_wdata) & `ERR_USED_MASK;           // RULE10 RULE18
         open_r  <= w1c(open_r, ch2_r[0] & open_en_r
                        & {8{open_mode == OPEN_AUTO}},
                        wr_en && reg_addr == `ADDR_OPEN_FLAGS,
                        reg_wdata);                            // RULE13 RULE18
         over_r  <= w1c(over_r, ch2_r[1] & range_en_r,
                        wr_en && reg_addr == `ADDR_OVER_FLAGS,
                        reg_wdata);                            // RULE15 RULE18
         under_r <= w1c(under_r, ch2_r[2] & range_en_r,
                        wr_en && reg_addr == `ADDR_UNDER_FLAGS,
                        reg_wdata);                            // RULE16 RULE18
      end
   end

   // ****************************************************************
   // Read-back
   // ****************************************************************
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= 8'h00;
      end else if (rd_en) begin
         case (reg_addr)
            `ADDR_CHECK_ENABLE: reg_rdata <= check_en_r;
            `ADDR_ERROR_FLAGS:  reg_rdata <= err_r; // RULE10
            `ADDR_OPEN_ENABLE:  reg_rdata <= open_en_r;
            `ADDR_OPEN_FLAGS:   reg_rdata <= open_r;
            `ADDR_RANGE_ENABLE: reg_rdata <= range_en_r;
            `ADDR_OVER_FLAGS:   reg_rdata <= over_r;
            `ADDR_UNDER_FLAGS:  reg_rdata <= under_r;
            default:            reg_rdata <= 8'h00;
         endcase
      end
   end

endmodule

// >>> tb/host_model.sv
`timescale 1ns/100ps
module host_model (
   input  wire logic               ref_clk,
   input  wire diag_pkg::byte_type reg_rdata,
   output      logic               reg_wr,
   output      logic               reg_rd,
   output      diag_pkg::addr_type reg_addr,
   output      diag_pkg::byte_type reg_wdata
);
   import diag_pkg::*;
   initial begin
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = 7'h00;
      reg_wdata = 8'h00;
   end
   // Clear masks carry ones only where meant
   task automatic wr(input addr_type a, input byte_type d);
      @(posedge ref_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input addr_type a, output byte_type d);
      @(posedge ref_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      // Read data stands from the edge after the request
      @(posedge ref_clk);
      d = reg_rdata;
   endtask
endmodule

// >>> tb/diag_checker_monitor.sv
`timescale 1ns/100ps
`include "diag_params.svh"
module diag_checker #(
   parameter int                 COUNT_W = 16,
   parameter diag_pkg::byte_type PATTERN = 8'hA5
) (
   input wire logic                    ref_clk,
   input wire logic                    arst_n,
   input wire logic                    reg_wr,
   input wire logic                    reg_rd,
   input wire diag_pkg::addr_type      reg_addr,
   input wire diag_pkg::byte_type      reg_wdata,
   input wire diag_pkg::byte_type      reg_rdata,
   input wire diag_pkg::open_mode_type open_mode,
   input wire logic                    busy_pin,
   input wire diag_pkg::byte_type      chan_open_check_enable,
   input wire diag_pkg::byte_type      chan_cm_high,
   input wire diag_pkg::byte_type      chan_range_check_enable,
   input wire logic [COUNT_W-1:0]      sample_clock_count,
   input wire logic [15:0]             conv_data_out
);
   import diag_pkg::*;
   byte_type en_r;
   byte_type rng_r;
   logic     rd_take;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   assign rd_take = reg_rd && !reg_wr;
   // Shadow of the check enable and range enable registers
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         en_r  <= `RST_CHECK_ENABLE;
         rng_r <= `RST_FLAGS;
      end else if (reg_wr && reg_addr == `ADDR_CHECK_ENABLE) begin
         en_r <= reg_wdata;
      end else if (reg_wr && reg_addr == `ADDR_RANGE_ENABLE) begin
         rng_r <= reg_wdata;
      end
   end
   property p_pattern;
      en_r[7] && $past(en_r[7]) |-> conv_data_out == {PATTERN, PATTERN};
   endproperty
   a_pattern: assert property (p_pattern)
      else $error("pattern missing");
   property p_count_hold;
      $past(arst_n) && !$past(en_r[6]) |-> $stable(sample_clock_count);
   endproperty
   a_count_hold: assert property (p_count_hold)
      else $error("count moved");
   property p_en_read;
      rd_take && reg_addr == `ADDR_CHECK_ENABLE |=> reg_rdata == $past(en_r);
   endproperty
   a_en_read: assert property (p_en_read)
      else $error("enable read");
   property p_rng_read;
      rd_take && reg_addr == `ADDR_RANGE_ENABLE |=> reg_rdata == $past(rng_r);
   endproperty
   a_rng_read: assert property (p_rng_read)
      else $error("range read");
   property p_rsvd;
      rd_take && reg_addr == `ADDR_ERROR_FLAGS |=> reg_rdata[7:6] == 2'b00;
   endproperty
   a_rsvd: assert property (p_rsvd)
      else $error("reserved bits set");
   property p_unmapped;
      rd_take && reg_addr > `ADDR_MAP_LAST |=> reg_rdata == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read");
   property p_rng_out;
      $past(arst_n) && $stable(rng_r) |-> chan_range_check_enable == rng_r;
   endproperty
   a_rng_out: assert property (p_rng_out)
      else $error("range out");
   property p_manual;
      open_mode && $past(open_mode) |-> chan_open_check_enable == 8'h00;
   endproperty
   a_manual: assert property (p_manual)
      else $error("open in manual");
   property p_auto;
      !open_mode && !$past(open_mode) |-> chan_cm_high == 8'h00;
   endproperty
   a_auto: assert property (p_auto)
      else $error("common mode in auto");
   c_busy: cover property (busy_pin [*8]);
   c_unmapped: cover property (rd_take && reg_addr > `ADDR_MAP_LAST);
   c_manual: cover property (open_mode && chan_cm_high != 8'h00);
endmodule
bind diag_monitor diag_checker #(.COUNT_W(COUNT_W), .PATTERN(PATTERN)) chk (
   .ref_clk(ref_clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .open_mode(open_mode), .busy_pin(busy_pin),
   .chan_open_check_enable(chan_open_check_enable),
   .chan_cm_high(chan_cm_high),
   .chan_range_check_enable(chan_range_check_enable),
   .sample_clock_count(sample_clock_count), .conv_data_out(conv_data_out));

// >>> tb/adc_diagnostic_monitor_regs_tb_top.sv
`timescale 1ns/100ps
`include "diag_params.svh"
module adc_diagnostic_monitor_regs_tb_top;
   import diag_pkg::*;
   localparam int       LIM = 5;
   localparam byte_type PAT = 8'h3C;
   logic ref_clk = 1'b0, arst_n = 1'b0, busy = 1'b0, cs = 1'b0, ovs = 1'b0;
   logic if_f = 1'b0, map_f = 1'b0, rom_f = 1'b0;
   open_mode_type mode = OPEN_AUTO;
   byte_type ev_o = 8'h00, ev_v = 8'h00, ev_u = 8'h00, oen, cmh, ren, v;
   logic [15:0] din = 16'h0000, dout, cnt, c0;
   logic reg_wr, reg_rd;
   addr_type reg_addr;
   byte_type reg_wdata, reg_rdata;
   int errors = 0, checked = 0;
   always #20 ref_clk = ~ref_clk;
   host_model h (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
   diag_monitor #(.PATTERN(PAT), .BUSY_LIMIT(LIM)) dut (.ref_clk(ref_clk),
      .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .open_mode(mode),
      .busy_pin(busy), .conversion_start_clock(cs), .oversampling_clock(ovs),
      .if_crc_fail(if_f), .map_crc_fail(map_f), .rom_crc_fail(rom_f),
      .chan_open_event(ev_o), .chan_over_event(ev_v), .chan_under_event(ev_u),
      .conv_data_in(din), .conv_data_out(dout), .chan_open_check_enable(oen),
      .chan_cm_high(cmh), .chan_range_check_enable(ren),
      .sample_clock_count(cnt));
   // ****************************************************************
   // Helpers
   // ****************************************************************
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checked++;
      if (g !== e) begin
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
         errors++;
      end
   endtask
   task automatic rdc(input addr_type a, input byte_type e);
      h.rd(a, v);
      chk({8'h00, v}, {8'h00, e});
   endtask
   task automatic faults(input logic f_if, input logic f_map,
                         input logic f_rom);
      @(posedge ref_clk);
      {if_f, map_f, rom_f} <= {f_if, f_map, f_rom};
      tick(2);
      {if_f, map_f, rom_f} <= 3'b000;
      tick(4);
   endtask
   task automatic pulses(input int n_cs, input int n_os);
      for (int i = 0; i < n_cs + n_os; i++) begin
         tick(1);
         if (i < n_cs) cs <= 1'b1;
         else ovs <= 1'b1;
         tick(3);
         {cs, ovs} <= 2'b00;
      end
      tick(6);
   endtask
   task automatic busy_for(input int n);
      @(posedge ref_clk);
      busy <= 1'b1;
      tick(n);
      busy <= 1'b0;
      tick(6);
   endtask
   task automatic stop_test;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // ****************************************************************
   // Tests
   // ****************************************************************
   task automatic t_reset;
      rdc(`ADDR_CHECK_ENABLE, 8'h01);
      for (int a = 8'h22; a <= 8'h27; a++) rdc(addr_type'(a), 8'h00);
      $display("test reset done");
   endtask
   task automatic t_digital;
      faults(1'b0, 1'b1, 1'b1);
      rdc(`ADDR_ERROR_FLAGS, 8'h01);
      h.wr(`ADDR_ERROR_FLAGS, 8'h01);
      rdc(`ADDR_ERROR_FLAGS, 8'h00);
      h.wr(`ADDR_CHECK_ENABLE, 8'h1E);
      faults(1'b1, 1'b1, 1'b1);
      rdc(7'h40, 8'h00);
      h.wr(7'h7F, 8'h55);
      rdc(`ADDR_ERROR_FLAGS, 8'h1E);
      h.wr(`ADDR_ERROR_FLAGS, 8'h08);
      rdc(`ADDR_ERROR_FLAGS, 8'h16);
      h.wr(`ADDR_ERROR_FLAGS, 8'h3F);
      busy_for(LIM + 3);
      rdc(`ADDR_ERROR_FLAGS, 8'h00);
      h.wr(`ADDR_CHECK_ENABLE, 8'h20);
      busy_for(LIM);
      rdc(`ADDR_ERROR_FLAGS, 8'h00);
      busy_for(LIM + 3);
      rdc(`ADDR_ERROR_FLAGS, 8'h20);
      $display("test digital done");
   endtask
   task automatic t_chan;
      h.wr(`ADDR_OPEN_ENABLE, 8'h81);
      h.wr(`ADDR_RANGE_ENABLE, 8'h3C);
      tick(2);
      chk(oen, 16'h0081);
      chk(ren, 16'h003C);
      ev_o <= 8'hFF;
      ev_v <= 8'hFF;
      ev_u <= 8'h0F;
      tick(2);
      {ev_o, ev_v, ev_u} <= 24'h000000;
      tick(4);
      rdc(`ADDR_OPEN_FLAGS, 8'h81);
      rdc(`ADDR_OVER_FLAGS, 8'h3C);
      rdc(`ADDR_UNDER_FLAGS, 8'h0C);
      mode <= OPEN_MANUAL;
      tick(2);
      chk(cmh, 16'h0081);
      h.wr(`ADDR_OPEN_FLAGS, 8'h01);
      rdc(`ADDR_OPEN_FLAGS, 8'h80);
      h.wr(`ADDR_OVER_FLAGS, 8'h0C);
      rdc(`ADDR_OVER_FLAGS, 8'h30);
      h.wr(`ADDR_UNDER_FLAGS, 8'h04);
      rdc(`ADDR_UNDER_FLAGS, 8'h08);
      $display("test channels done");
   endtask
   task automatic t_data;
      din <= 16'h1234;
      tick(2);
      chk(dout, 16'h1234);
      h.wr(`ADDR_CHECK_ENABLE, 8'hC0);
      tick(2);
      chk(dout, {PAT, PAT});
      c0 = cnt;
      pulses(3, 2);
      chk(cnt, c0 + 16'h0005);
      h.wr(`ADDR_CHECK_ENABLE, 8'h00);
      tick(2);
      c0 = cnt;
      pulses(1, 1);
      chk(cnt, c0);
      $display("test data done");
   endtask
   initial begin
      tick(20);
      arst_n <= 1'b1;
      t_reset;
      t_digital;
      t_chan;
      t_data;
      stop_test;
   end
   initial begin
      #200000;
      errors++;
      stop_test;
   end
endmodule
